// ### ibc_top.sv
// image boot, mode and interrupt control top
`timescale 1ns/10ps
module ibc_top
  import ibc_pkg::*;
#(
  parameter logic [15:0] PRODUCT_CODE  = 16'h1234, // arbitrary value
  parameter logic [15:0] VERSION_CODE  = 16'h0200, // arbitrary value
  parameter logic [31:0] CSUM_ONE      = 32'h1111_2222,
  parameter logic [31:0] CSUM_TWO      = 32'h3333_4444,
  parameter logic [31:0] ACTIVATE_CODE = 32'hA5A5_5A5A
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial control port
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        cdata,
  output logic             rdata,
  output logic             rdata_oe,
  // boot straps
  input  wire logic        boot_strap_first,
  input  wire logic        boot_strap_second,
  // eeprom fetch handshake
  output logic             ee_fetch_start,
  input  wire logic        ee_fetch_done,
  // modem outputs
  output logic             interrupt_request_n,
  output logic             transmit_enable_out_n,
  output logic             receive_enable_out_n,
  output logic             fast_clock_sel,
  output logic [3:0]       modem_function,
  output logic             image_ready,
  // status events from modem core
  input  wire logic [14:1] event_flags
);
  typedef struct packed {
    ibc_boot_e   st;
    logic        have_image;
    logic        code_half;
    logic [15:0] code_hi;
    logic [15:0] mode;
    logic [15:0] aux;
    logic [15:0] mask;
    logic [15:0] status;
    logic [15:0] rd_word;
    logic        atog_seen;
    logic        dtog_seen;
    logic        ee_start;
    logic        irq_n;
    logic        txe_n;
    logic        rxe_n;
    logic        fast;
    logic [3:0]  func;
    logic        ready;
    logic [2:0]  wait_cnt;
  } ibc_top_s;
  ibc_top_s s_q, s_d;

  logic        atog_l, dtog_l;
  ibc_req_s    req_l;
  logic [1:0]  straps_s;
  logic        atog_s, dtog_s, ee_done_s;
  logic [14:1] ev_prev_q;
  logic        gen_reset;
  logic [15:0] status_rise, mask_rise;

  ibc_link u_link (
    .sclk     (sclk),
    .cs_n     (cs_n),
    .cdata    (cdata),
    .rdata    (rdata),
    .rdata_oe (rdata_oe),
    .rd_word  (s_q.rd_word),
    .addr_tog (atog_l),
    .done_tog (dtog_l),
    .req      (req_l)
  );

  // frame flags and straps cross by three-stage sync
  ibc_sync #(.W(5)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({boot_strap_second, boot_strap_first, atog_l, dtog_l, ee_fetch_done}),
    .sync_out ({straps_s, atog_s, dtog_s, ee_done_s})
  );

  // req is stable long before the synced flag lands; only its rise counts
  logic addr_ev, done_ev;
  assign addr_ev = atog_s & ~s_q.atog_seen;
  assign done_ev = dtog_s & ~s_q.dtog_seen;
  assign gen_reset = done_ev & ~req_l.is_write & (req_l.addr == ADDR_GEN_RESET);
  logic prog_wr;
  assign prog_wr = done_ev & req_l.is_write & (req_l.addr == ADDR_PROGRAMMING)
                   & (s_q.mode[1:0] == MODE_IDLE);

  always_comb begin
    s_d = s_q;
    s_d.atog_seen = atog_s;
    s_d.dtog_seen = dtog_s;
    s_d.ee_start = 1'b0;
    status_rise = '0;
    mask_rise = '0;
    status_rise[14:1] = event_flags & ~ev_prev_q;
    if (addr_ev && !req_l.is_write) begin
      case (req_l.addr)
        ADDR_PRODUCT_ID:  s_d.rd_word = (s_q.st == BOOT_AWAIT) ? PRODUCT_CODE : RESET_WORD;
        ADDR_IMG_VERSION: s_d.rd_word = (s_q.st == BOOT_AWAIT) ? VERSION_CODE : RESET_WORD;
        ADDR_CSUM1_HI:    s_d.rd_word = (s_q.st == BOOT_DEAD) ? DEAD_CODE :
                                        (s_q.st == BOOT_AWAIT) ? CSUM_ONE[31:16] : RESET_WORD;
        ADDR_CSUM1_LO:    s_d.rd_word = (s_q.st == BOOT_AWAIT) ? CSUM_ONE[15:0] : RESET_WORD;
        ADDR_CSUM2_HI:    s_d.rd_word = (s_q.st == BOOT_AWAIT) ? CSUM_TWO[31:16] : RESET_WORD;
        ADDR_CSUM2_LO:    s_d.rd_word = (s_q.st == BOOT_AWAIT) ? CSUM_TWO[15:0] : RESET_WORD;
        ADDR_STATUS:      s_d.rd_word = s_q.status;
        default:          s_d.rd_word = RESET_WORD;
      endcase
    end
    case (s_q.st)
      BOOT_SAMPLE: begin
        if (s_q.wait_cnt != 3'(LOAD_WAIT_CYCLES)) begin
          s_d.wait_cnt = s_q.wait_cnt + 3'd1;
        end else if (straps_s == 2'b11) begin
          s_d.st = BOOT_HOST_LOAD;
        end else if (straps_s == 2'b01) begin
          s_d.st = BOOT_EE_LOAD;
          s_d.ee_start = 1'b1;
        end else if (straps_s == 2'b00 && s_q.have_image) begin
          s_d.st = BOOT_REPORT;
        end
      end
      BOOT_HOST_LOAD: begin
        if (prog_wr) begin
          s_d.st = BOOT_REPORT;
        end
      end
      BOOT_EE_LOAD: begin
        if (ee_done_s) begin
          s_d.st = BOOT_REPORT;
        end
      end
      BOOT_REPORT: begin
        s_d.have_image = 1'b1;
        s_d.code_half = 1'b0;
        s_d.st = BOOT_AWAIT;
      end
      BOOT_AWAIT: begin
        if (prog_wr) begin
          if (!s_q.code_half) begin
            s_d.code_hi = req_l.data;
            s_d.code_half = 1'b1;
          end else if ({s_q.code_hi, req_l.data} == ACTIVATE_CODE) begin
            // activated, ids hidden until the next general reset
            s_d.st = BOOT_READY;
            s_d.mode = RESET_WORD;
            s_d.status[PRG_BIT] = 1'b1;
          end else begin
            s_d.st = BOOT_DEAD;
          end
        end
      end
      BOOT_READY: begin
        if (done_ev && req_l.is_write) begin
          case (req_l.addr)
            ADDR_MODE_CTRL: s_d.mode = req_l.data;
            ADDR_AUX_CFG:   s_d.aux = req_l.data;
            ADDR_IRQ_MASK: begin
              s_d.mask = req_l.data;
              mask_rise = req_l.data & ~s_q.mask;
            end
            default: s_d.mode = s_q.mode;
          endcase
        end
      end
      BOOT_DEAD: s_d.st = BOOT_DEAD;
      default:   s_d.st = BOOT_SAMPLE;
    endcase
    // ready flag follows program acceptance (idle)
    if (s_q.st == BOOT_READY) begin
      s_d.status[PRG_BIT] = (s_d.mode[1:0] == MODE_IDLE);
    end
    // clear on status read address phase
    if (addr_ev && !req_l.is_write && req_l.addr == ADDR_STATUS) begin
      s_d.status[15:1] = '0;
    end
    // set wins over clear
    s_d.status[14:1] = s_d.status[14:1] | status_rise[14:1];
    // rise of an unmasked flag or of a mask bit
    if (|(status_rise[14:1] & s_q.mask[14:1]) || |(mask_rise[14:1] & s_q.status[14:1])) begin
      s_d.status[IRQ_BIT] = 1'b1;
    end
    s_d.irq_n = ~(s_d.status[IRQ_BIT] & s_d.mask[IRQ_BIT]);
    s_d.txe_n = 1'b1;
    s_d.rxe_n = 1'b1;
    if (s_d.mode[1:0] == MODE_TX) begin
      if (s_d.aux[0]) s_d.rxe_n = 1'b0;
      else            s_d.txe_n = 1'b0;
    end else if (s_d.mode[1:0] == MODE_RX) begin
      if (s_d.aux[0]) s_d.txe_n = 1'b0;
      else            s_d.rxe_n = 1'b0;
    end
    // fast clock in rx or tx
    s_d.fast = (s_d.mode[1:0] == MODE_RX) || (s_d.mode[1:0] == MODE_TX);
    // reserved functions fall back to idle
    case (s_d.mode[7:4])
      FUNC_IDLE, FUNC_RAW, FUNC_EYE_PRBS, FUNC_PREAMBLE,
      FUNC_SYNC_TEST, FUNC_ABORT: s_d.func = s_d.mode[7:4];
      default:                    s_d.func = FUNC_IDLE;
    endcase
    s_d.ready = (s_q.st == BOOT_READY);
    // general reset returns to idle, straps resampled, except in the dead state
    if (gen_reset && s_q.st != BOOT_DEAD) begin
      s_d.st = BOOT_SAMPLE;
      s_d.wait_cnt = 3'd0;
      s_d.mode = RESET_WORD;
      s_d.status = RESET_WORD;
      s_d.mask = RESET_WORD;
      s_d.txe_n = 1'b1;
      s_d.rxe_n = 1'b1;
      s_d.fast = 1'b0;
      s_d.func = FUNC_IDLE;
      s_d.irq_n = 1'b1;
      s_d.ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{st: BOOT_SAMPLE, irq_n: 1'b1, txe_n: 1'b1, rxe_n: 1'b1, default: '0};
      ev_prev_q <= '0;
    end else begin
      s_q <= s_d;
      ev_prev_q <= event_flags;
    end
  end

  assign ee_fetch_start        = s_q.ee_start;
  assign interrupt_request_n   = s_q.irq_n;
  assign transmit_enable_out_n = s_q.txe_n;
  assign receive_enable_out_n  = s_q.rxe_n;
  assign fast_clock_sel        = s_q.fast;
  assign modem_function        = s_q.func;
  assign image_ready           = s_q.ready;

  // assertions
  property p_irq_follows;
    @(posedge clk) disable iff (!rst_n)
      (s_q.status[IRQ_BIT] && s_q.mask[IRQ_BIT]) |-> !interrupt_request_n;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not asserted");

  property p_tx_enable;
    @(posedge clk) disable iff (!rst_n)
      (s_q.mode[1:0] == MODE_TX && !s_q.aux[0]) |-> (!transmit_enable_out_n && receive_enable_out_n);
  endproperty
  a_tx_enable: assert property (p_tx_enable) else $error("tx enable wrong");

  property p_swap;
    @(posedge clk) disable iff (!rst_n)
      (s_q.mode[1:0] == MODE_RX && s_q.aux[0]) |-> (!transmit_enable_out_n && receive_enable_out_n);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_fast;
    @(posedge clk) disable iff (!rst_n)
      (s_q.mode[1:0] == MODE_IDLE) |-> !fast_clock_sel;
  endproperty
  a_fast: assert property (p_fast) else $error("clock not slow in idle");

  property p_dead_stays;
    @(posedge clk) disable iff (!rst_n)
      (s_q.st == BOOT_DEAD) |=> (s_q.st == BOOT_DEAD);
  endproperty
  a_dead_stays: assert property (p_dead_stays) else $error("left dead state");

  property p_ready_flag;
    @(posedge clk) disable iff (!rst_n)
      s_q.status[PRG_BIT] |-> (s_q.st == BOOT_READY || $past(s_q.st) == BOOT_AWAIT);
  endproperty
  a_ready_flag: assert property (p_ready_flag) else $error("ready flag early");

  property p_status_clear;
    @(posedge clk) disable iff (!rst_n)
      (addr_ev && !req_l.is_write && req_l.addr == ADDR_STATUS && event_flags == ev_prev_q
       && !gen_reset) |=> (s_q.status[15:1] == '0);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_func_legal;
    @(posedge clk) disable iff (!rst_n)
      (modem_function != FUNC_IDLE) |-> (modem_function == s_q.mode[7:4]);
  endproperty
  a_func_legal: assert property (p_func_legal) else $error("bad modem function");

  property p_gen_reset_idle;
    @(posedge clk) disable iff (!rst_n)
      (gen_reset && s_q.st != BOOT_DEAD) |=>
        (!fast_clock_sel && transmit_enable_out_n && receive_enable_out_n && !image_ready);
  endproperty
  a_gen_reset_idle: assert property (p_gen_reset_idle) else $error("reset left mode on");

  property p_activate;
    @(posedge clk) disable iff (!rst_n)
      (s_q.st == BOOT_AWAIT && prog_wr && s_q.code_half
       && {s_q.code_hi, req_l.data} == ACTIVATE_CODE) |-> ##2 image_ready;
  endproperty
  a_activate: assert property (p_activate) else $error("valid code not taken");

  c_ready: cover property (@(posedge clk) disable iff (!rst_n) s_q.st == BOOT_READY);
  c_dead:  cover property (@(posedge clk) disable iff (!rst_n) s_q.st == BOOT_DEAD);
  c_irq:   cover property (@(posedge clk) disable iff (!rst_n) !interrupt_request_n);
endmodule

// ### ibc_pkg.sv
// package: register map, states and link structs for the image boot control block
package ibc_pkg;
  localparam logic [7:0] ADDR_GEN_RESET    = 8'h01;
  localparam logic [7:0] ADDR_AUX_CFG      = 8'hA7;
  localparam logic [7:0] ADDR_CSUM1_HI     = 8'hA9;
  localparam logic [7:0] ADDR_CSUM1_LO     = 8'hAA;
  localparam logic [7:0] ADDR_OUT_GAIN     = 8'hB0;
  localparam logic [7:0] ADDR_IN_ROUTING   = 8'hB1;
  localparam logic [7:0] ADDR_CSUM2_HI     = 8'hB8;
  localparam logic [7:0] ADDR_CSUM2_LO     = 8'hB9;
  localparam logic [7:0] ADDR_POWER_DOWN   = 8'hC0;
  localparam logic [7:0] ADDR_MODE_CTRL    = 8'hC1;
  localparam logic [7:0] ADDR_PRODUCT_ID   = 8'hC5;
  localparam logic [7:0] ADDR_STATUS       = 8'hC6;
  localparam logic [7:0] ADDR_MODEM_CFG    = 8'hC7;
  localparam logic [7:0] ADDR_PROGRAMMING  = 8'hC8;
  localparam logic [7:0] ADDR_IMG_VERSION  = 8'hC9;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'hCE;
  localparam logic [15:0] DEAD_CODE        = 16'hDEAD;
  localparam int          IRQ_BIT          = 15;
  localparam int          PRG_BIT          = 0;
  localparam logic [15:0] RESET_WORD       = 16'h0000;
  localparam logic [1:0]  MODE_IDLE        = 2'b00;
  localparam logic [1:0]  MODE_RX          = 2'b01;
  localparam logic [1:0]  MODE_TX          = 2'b10;
  localparam logic [3:0]  FUNC_IDLE        = 4'h0;
  localparam logic [3:0]  FUNC_RAW         = 4'h2;
  localparam logic [3:0]  FUNC_EYE_PRBS    = 4'h3;
  localparam logic [3:0]  FUNC_PREAMBLE    = 4'h4;
  localparam logic [3:0]  FUNC_SYNC_TEST   = 4'h6;
  localparam logic [3:0]  FUNC_ABORT       = 4'h7;
  localparam int          LOAD_WAIT_CYCLES = 4;

  typedef enum logic [2:0] {
    BOOT_HOST_LOAD = 3'b000,
    BOOT_EE_LOAD   = 3'b001,
    BOOT_REPORT    = 3'b010,
    BOOT_AWAIT     = 3'b011,
    BOOT_READY     = 3'b100,
    BOOT_DEAD      = 3'b101,
    BOOT_SAMPLE    = 3'b110
  } ibc_boot_e;

  typedef struct packed {
    logic        is_write;
    logic [7:0]  addr;
    logic [15:0] data;
  } ibc_req_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       last;
    logic       seen;
  } ibc_tog_s;
endpackage

// ### ibc_link.sv
// serial control port shifter on the link clock
`timescale 1ns/10ps
module ibc_link
  import ibc_pkg::*;
(
  // link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        cdata,
  output logic             rdata,
  output logic             rdata_oe,
  // read data from system side, stable while a read is open
  input  wire logic [15:0] rd_word,
  // transfer flags, high from the event to frame end
  output logic             addr_tog,
  output logic             done_tog,
  output ibc_req_s         req
);
  typedef struct packed {
    logic [5:0]  cnt;
    logic [23:0] sh;
    logic        is_rd;
    logic        alvl;
    logic        dlvl;
  } ibc_link_s;
  ibc_link_s   s_q, s_d;
  ibc_req_s    req_q, req_d;
  logic [15:0] rsh_q;
  logic        rdata_q;
  logic        oe_q;
  logic [7:0]  abyte;
  logic        rd_addr;

  assign abyte = {s_q.sh[6:0], cdata};

  // the address byte alone decides the direction of a frame
  always_comb begin
    case (abyte)
      ADDR_CSUM1_HI, ADDR_CSUM1_LO, ADDR_CSUM2_HI, ADDR_CSUM2_LO,
      ADDR_PRODUCT_ID, ADDR_STATUS, ADDR_IMG_VERSION: rd_addr = 1'b1;
      default:                                        rd_addr = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    req_d = req_q;
    s_d.sh = {s_q.sh[22:0], cdata};
    s_d.cnt = (s_q.cnt == 6'd24) ? 6'd24 : s_q.cnt + 6'd1;
    // address byte complete: announce it so status clear can fire
    if (s_q.cnt == 6'd7) begin
      s_d.alvl = 1'b1;
      s_d.is_rd = rd_addr;
      req_d.addr = abyte;
      req_d.is_write = 1'b0;
      req_d.data = RESET_WORD;
      // command byte with no data
      if (abyte == ADDR_GEN_RESET) begin
        s_d.dlvl = 1'b1;
      end
    end
    // write data only behind a write address
    if (s_q.cnt == 6'd23 && !s_q.is_rd) begin
      req_d.is_write = 1'b1;
      req_d.data = {s_q.sh[14:0], cdata};
      s_d.dlvl = 1'b1;
    end
  end

  // cs_n high ends the frame and drops the flags, so a stopped clock is harmless
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // request outlives the frame until the system side has taken it
  always_ff @(posedge sclk) begin
    req_q <= req_d;
  end

  // read data msb first from falling sclk; host must leave time for rd_word
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rsh_q   <= '0;
      rdata_q <= 1'b0;
      oe_q    <= 1'b0;
    end else if (s_q.cnt == 6'd8) begin
      rsh_q   <= {rd_word[14:0], 1'b0};
      rdata_q <= rd_word[15];
      oe_q    <= s_q.is_rd;
    end else begin
      rsh_q   <= {rsh_q[14:0], 1'b0};
      rdata_q <= rsh_q[15];
    end
  end

  assign rdata    = rdata_q;
  assign rdata_oe = oe_q;
  assign addr_tog = s_q.alvl;
  assign done_tog = s_q.dlvl;
  assign req      = req_q;
endmodule

// ### ibc_sync.sv
// three-stage synchroniser with agreement detection
`timescale 1ns/10ps
module ibc_sync
  import ibc_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // async in, sync out
  input  wire logic [W-1:0] async_in,
  output logic [W-1:0]      sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } ibc_sync_s;
  ibc_sync_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a change counts once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.out[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.out;
endmodule

// ### ibc_host_model.sv
// host controller model driving the serial control port
`timescale 1ns/10ps
module ibc_host_model (
  // serial control port
  output logic      sclk,
  output logic      cs_n,
  output logic      cdata,
  input  wire logic rdata,
  input  wire logic rdata_oe
);
  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    cdata = 1'b0;
  end

  // one bit: launch while sclk low, sample read data while high
  task automatic put_bit(input logic v, input int hold, output logic got);
    cdata = v;
    #40;
    sclk = 1'b1;
    got = rdata_oe ? rdata : 1'bx;
    #(40 + hold);
    sclk = 1'b0;
  endtask

  // link clock only runs inside a frame
  task automatic frame(input logic [7:0] a, input int n, input logic [15:0] wd,
                       input logic rd, output logic [15:0] rw);
    logic g;
    rw = 16'h0000;
    cs_n = 1'b0;
    #15;
    for (int i = 7; i >= 1; i--) put_bit(a[i], 0, g);
    // last address bit held high on a read so the read word is in place
    put_bit(a[0], rd ? 100 : 0, g);
    for (int i = n - 1; i >= 0; i--) begin
      put_bit(rd ? i[0] : wd[i], 0, g);
      rw[i] = g;
    end
    #15;
    cs_n = 1'b1;
    cdata = ~cdata;
    // idle gap lets the crossing settle
    #1000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] x;
    frame(a, 16, d, 1'b0, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    frame(a, 16, 16'h0000, 1'b1, d);
  endtask

  task automatic cmd(input logic [7:0] a);
    logic [15:0] x;
    frame(a, 0, 16'h0000, 1'b0, x);
  endtask
endmodule

// ### test_image_boot_mode_irq_control.sv
// self-checking bench for the image boot, mode and interrupt block
`timescale 1ns/10ps
module test_image_boot_mode_irq_control
  import ibc_pkg::*;
;
  localparam logic [15:0] PCODE = 16'h4A1C; // arbitrary value
  localparam logic [15:0] VCODE = 16'h0305; // arbitrary value
  localparam logic [31:0] CS1   = 32'h0BAD_F00D;
  localparam logic [31:0] CS2   = 32'h5EED_C0DE;
  localparam logic [31:0] ACT   = 32'h6C3E_91D7;

  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        cs_n;
  logic        cdata;
  logic        rdata;
  logic        rdata_oe;
  logic        s1;
  logic        s2;
  logic        ee_start;
  logic        ee_done;
  logic        irq_n;
  logic        tx_n;
  logic        rx_n;
  logic        fast;
  logic [3:0]  func;
  logic        ready;
  logic [14:1] ev;
  int          n_mismatch;
  int          tests_run;

  ibc_top #(.PRODUCT_CODE(PCODE), .VERSION_CODE(VCODE), .CSUM_ONE(CS1), .CSUM_TWO(CS2),
            .ACTIVATE_CODE(ACT)) DUT (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .cdata(cdata), .rdata(rdata),
    .rdata_oe(rdata_oe), .boot_strap_first(s1), .boot_strap_second(s2),
    .ee_fetch_start(ee_start), .ee_fetch_done(ee_done), .interrupt_request_n(irq_n),
    .transmit_enable_out_n(tx_n), .receive_enable_out_n(rx_n), .fast_clock_sel(fast),
    .modem_function(func), .image_ready(ready), .event_flags(ev)
  );

  ibc_host_model host (
    .sclk(sclk), .cs_n(cs_n), .cdata(cdata), .rdata(rdata), .rdata_oe(rdata_oe)
  );

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    s1 = 1'b0;
    s2 = 1'b0;
    ee_done = 1'b0;
    ev = '0;
    n_mismatch = 0;
    tests_run = 0;
  end

  always #5 clk = ~clk;

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask

  task automatic por();
    rst_n = 1'b0;
    repeat (10) tick();
    rst_n = 1'b1;
  endtask

  // activation word goes as two halves, upper first
  task automatic act(input logic [31:0] c);
    host.wr(ADDR_PROGRAMMING, c[31:16]);
    host.wr(ADDR_PROGRAMMING, c[15:0]);
  endtask

  task automatic rep_chk(input logic on);
    rdchk(ADDR_PRODUCT_ID, on ? PCODE : 16'h0000);
    rdchk(ADDR_IMG_VERSION, on ? VCODE : 16'h0000);
    rdchk(ADDR_CSUM1_HI, on ? CS1[31:16] : 16'h0000);
    rdchk(ADDR_CSUM1_LO, on ? CS1[15:0] : 16'h0000);
    rdchk(ADDR_CSUM2_HI, on ? CS2[31:16] : 16'h0000);
    rdchk(ADDR_CSUM2_LO, on ? CS2[15:0] : 16'h0000);
  endtask

  task automatic t_host_load();
    s1 = 1'b1;
    s2 = 1'b1;
    por();
    repeat (20) tick();
    chk({irq_n, tx_n, rx_n, fast, ready}, 5'b11100, "reset levels");
    host.wr(ADDR_PROGRAMMING, 16'h0F0F);
    rep_chk(1'b1);
    // writes other than the code are refused while waiting
    host.wr(ADDR_MODE_CTRL, 16'h0001);
    chk({rx_n, fast, ready}, 3'b100, "early mode write");
    act(ACT);
    chk(ready, 1'b1, "not activated");
    rdchk(ADDR_STATUS, 16'h0001);
    rep_chk(1'b0);
  endtask

  task automatic t_modes();
    logic [5:0] tbl [9];
    logic [1:0] md;
    logic [3:0] fn;
    tbl = '{6'h12, 6'h23, 6'h00, 6'h24, 6'h16, 6'h27, 6'h11, 6'h28, 6'h30};
    for (int sw = 0; sw < 2; sw++) begin
      host.wr(ADDR_AUX_CFG, {15'h0000, sw[0]});
      foreach (tbl[k]) begin
        md = tbl[k][5:4];
        fn = tbl[k][3:0];
        host.wr(ADDR_MODE_CTRL, {8'h00, fn, 2'b00, md});
        chk(tx_n, !((md == MODE_TX && !sw[0]) || (md == MODE_RX && sw[0])), "tx en");
        chk(rx_n, !((md == MODE_RX && !sw[0]) || (md == MODE_TX && sw[0])), "rx en");
        chk(func, (fn == 4'h1 || fn[3]) ? FUNC_IDLE : fn, "function");
        if (md != 2'b11) chk(fast, md != MODE_IDLE, "speed");
      end
    end
    host.wr(ADDR_AUX_CFG, 16'h0000);
    // programming not allowed outside idle
    host.wr(ADDR_MODE_CTRL, 16'h0001);
    rdchk(ADDR_STATUS, 16'h0000);
    host.wr(ADDR_MODE_CTRL, 16'h0000);
    rdchk(ADDR_STATUS, 16'h0001);
    chk({fast, tx_n, rx_n}, 3'b011, "idle again");
  endtask

  task automatic pulse(input int b);
    ev[b] = 1'b1;
    tick();
    ev = '0;
    repeat (8) tick();
  endtask

  task automatic t_irq();
    host.wr(ADDR_IRQ_MASK, 16'h8002);
    pulse(1);
    chk(irq_n, 1'b0, "irq on flag rise");
    rdchk(ADDR_STATUS, 16'h8003);
    chk(irq_n, 1'b1, "irq after read");
    rdchk(ADDR_STATUS, 16'h0001);
    host.wr(ADDR_IRQ_MASK, 16'h8000);
    pulse(2);
    chk(irq_n, 1'b1, "masked flag");
    host.wr(ADDR_IRQ_MASK, 16'h8004);
    chk(irq_n, 1'b0, "irq on mask rise");
    rdchk(ADDR_STATUS, 16'h8005);
    chk(irq_n, 1'b1, "irq cleared");
  endtask

  task automatic t_gen_reset();
    s1 = 1'b0;
    s2 = 1'b0;
    host.cmd(ADDR_GEN_RESET);
    chk({ready, tx_n, rx_n}, 3'b011, "after general reset");
    rdchk(ADDR_CSUM1_HI, CS1[31:16]);
    // straps now ignored until the next reset
    s1 = 1'b1;
    s2 = 1'b1;
    act(ACT);
    chk(ready, 1'b1, "reactivation");
  endtask

  task automatic t_ee_dead();
    int k;
    s1 = 1'b1;
    s2 = 1'b0;
    por();
    for (k = 0; k < 80 && ee_start !== 1'b1; k++) tick();
    chk(ee_start, 1'b1, "no fetch start");
    ee_done = 1'b1;
    repeat (20) tick();
    rep_chk(1'b1);
    act({ACT[31:16], ~ACT[15:0]});
    rdchk(ADDR_CSUM1_HI, DEAD_CODE);
    s1 = 1'b0;
    host.cmd(ADDR_GEN_RESET);
    act(ACT);
    chk(ready, 1'b0, "dead device woke");
    rdchk(ADDR_CSUM1_HI, DEAD_CODE);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // run is near 193 us, so 600 us means a hang
  initial begin
    #600000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    t_host_load();
    t_modes();
    t_irq();
    t_gen_reset();
    t_ee_dead();
    conclude();
  end
endmodule
